//--- rx_timeslot_monitor.sv
// Receive single-timeslot monitor with its two parallel-port registers.
// Assumes line clock, data and frame marker are asynchronous pins.
//
// Behaviour
// [RULE1] Bits 4..0 of control select channel
// [RULE2] Software writes zero to bits 6, 5
// [RULE3] First received bit lands in bit 7
// [RULE4] Last bit in bit 0, arrival order
// [RULE5] Channel N is timeslot N minus 1
// [RULE6] Software writes channel number in binary
// [RULE7] Snapshot read-only, updates after whole byte
`timescale 1ns/1ps
module rx_timeslot_monitor
    import rx_timeslot_monitor_pkg::*;
#(
    parameter int SYNC_DEPTH = SYNC_STAGES
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire host_req_t i_host,
    input wire rx_line_t i_rx_line,
    output logic [DATA_W-1:0] o_rdata,
    output logic [SEL_W-1:0] o_chan_sel
);
    // Pin synchronisers and filtered levels
    logic [SYNC_DEPTH-1:0] clk_sync;
    logic [SYNC_DEPTH-1:0] data_sync;
    logic [SYNC_DEPTH-1:0] frame_sync;
    logic clk_filt;
    logic data_filt;
    logic frame_filt;
    logic next_clk_filt;
    logic next_data_filt;
    logic next_frame_filt;
    logic bit_edge;
    // Register decode
    logic ctrl_wr;
    logic [DATA_W-1:0] ctrl_view;
    // Channel select and frame position
    logic [SEL_W-1:0] chan_sel;
    logic [SEL_W-1:0] target_slot;
    logic [FRAME_POS_W-1:0] bit_pos;
    logic [FRAME_POS_W-1:0] cur_pos;
    logic [SEL_W-1:0] slot_num;
    logic [SLOT_IDX_W-1:0] bit_idx;
    logic slot_hit;
    logic slot_done;
    // Byte assembly and monitor register
    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] snapshot;

    // Filter reads the last two stages behind the pin flop
    if (SYNC_DEPTH < SYNC_STAGES) begin : g_sync_depth_check
        $error("SYNC_DEPTH must be at least three");
    end

    // Monitor register holds exactly one timeslot
    if (BITS_PER_SLOT != DATA_W) begin : g_slot_width_check
        $error("Timeslot width must equal register width");
    end

    // Frame position splits into slot number and bit index
    if (FRAME_POS_W != SEL_W + SLOT_IDX_W) begin : g_frame_split_check
        $error("Frame position width does not split evenly");
    end

    // Select field must leave room for zero fill
    if (DATA_W <= SEL_W) begin : g_select_fit_check
        $error("Select field wider than register");
    end

    // Filtered level: follows only when the last two stages agree
    function automatic logic filt_level(input logic [SYNC_DEPTH-1:0] s, input logic prev);
        filt_level = (s[SYNC_DEPTH-2] == s[SYNC_DEPTH-1]) ? s[SYNC_DEPTH-1] : prev;
    endfunction

    // Register address match
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
            input logic [ADDR_W-1:0] reg_addr);
        addr_is = (addr == reg_addr);
    endfunction

    // [RULE5] Channel N is timeslot N minus 1
    function automatic logic [SEL_W-1:0] chan_to_slot(input logic [SEL_W-1:0] chan);
        chan_to_slot = chan - SEL_CHAN_OFFSET;
    endfunction

    // Line clock pin synchroniser
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_sync <= '0;
        end else begin
            clk_sync <= {clk_sync[SYNC_DEPTH-2:0], i_rx_line.clk};
        end
    end

    // Line data pin synchroniser
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            data_sync <= '0;
        end else begin
            data_sync <= {data_sync[SYNC_DEPTH-2:0], i_rx_line.data};
        end
    end

    // Frame marker pin synchroniser
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            frame_sync <= '0;
        end else begin
            frame_sync <= {frame_sync[SYNC_DEPTH-2:0], i_rx_line.frame};
        end
    end

    // Next filtered levels
    always_comb begin
        next_clk_filt = filt_level(clk_sync, clk_filt);
        next_data_filt = filt_level(data_sync, data_filt);
        next_frame_filt = filt_level(frame_sync, frame_filt);
    end

    // Filtered line clock level
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_filt <= 1'b0;
        end else begin
            clk_filt <= next_clk_filt;
        end
    end

    // Filtered line data level
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            data_filt <= 1'b0;
        end else begin
            data_filt <= next_data_filt;
        end
    end

    // Filtered frame marker level
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            frame_filt <= 1'b0;
        end else begin
            frame_filt <= next_frame_filt;
        end
    end

    // Rising line clock edge takes one bit
    assign bit_edge = next_clk_filt && !clk_filt;

    // Control register write decode
    assign ctrl_wr = i_host.wr && addr_is(i_host.addr, ADDR_COMMON_CONTROL_FIVE);

    // Control register write
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            chan_sel <= SEL_RESET;
        end else if (ctrl_wr) begin
            // [RULE1] Select field capture
            chan_sel <= i_host.wdata[SEL_MSB:SEL_LSB];
        end
    end

    // Select field observation
    assign o_chan_sel = chan_sel;

    // Unbuilt control bits read as zero
    assign ctrl_view = {{(DATA_W-SEL_W){1'b0}}, chan_sel};

    // [RULE5] Selected channel to timeslot
    assign target_slot = chan_to_slot(chan_sel);

    // Bit position in the frame; marker flags bit zero
    assign cur_pos = next_frame_filt ? POS_FIRST : bit_pos;
    assign slot_num = cur_pos[FRAME_POS_W-1:SLOT_IDX_W];
    assign bit_idx = cur_pos[SLOT_IDX_W-1:0];
    assign slot_hit = (slot_num == target_slot);

    // [RULE7] Last bit of the selected slot
    assign slot_done = bit_edge && slot_hit && (bit_idx == LAST_BIT_IDX);

    // Frame bit counter
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_pos <= POS_FIRST;
        end else if (bit_edge) begin
            bit_pos <= next_frame_filt ? POS_AFTER_FIRST : FRAME_POS_W'(bit_pos + POS_STEP);
        end
    end

    // [RULE3] First bit ends in bit 7
    // [RULE4] Later bits follow toward bit 0
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            shift <= SNAPSHOT_RESET;
        end else if (bit_edge && slot_hit) begin
            shift <= {shift[DATA_W-2:0], next_data_filt};
        end
    end

    // [RULE7] Whole-byte snapshot load
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            snapshot <= SNAPSHOT_RESET;
        end else if (slot_done) begin
            snapshot <= {shift[DATA_W-2:0], next_data_filt};
        end
    end

    // [RULE7] Registered read data; snapshot has no write path
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= READ_ZERO;
        end else if (i_host.rd) begin
            unique case (i_host.addr)
                ADDR_COMMON_CONTROL_FIVE: o_rdata <= ctrl_view;
                ADDR_RX_TIMESLOT_SNAPSHOT: o_rdata <= snapshot;
                default: o_rdata <= READ_ZERO;
            endcase
        end
    end
endmodule

//--- rx_timeslot_monitor_pkg.sv
// Constants, register map and carrier types for the receive timeslot monitor.
// Assumes a single core clock domain; line signals arrive asynchronously.
package rx_timeslot_monitor_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_COMMON_CONTROL_FIVE = 8'hAA;
    localparam logic [ADDR_W-1:0] ADDR_RX_TIMESLOT_SNAPSHOT = 8'hAB;
    localparam int SEL_MSB = 4;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = SEL_MSB - SEL_LSB + 1;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
    localparam logic [SEL_W-1:0] SEL_CHAN_OFFSET = 5'h01;
    localparam logic [DATA_W-1:0] SNAPSHOT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam int BITS_PER_SLOT = 8;
    localparam int SLOT_IDX_W = 3;
    localparam int FRAME_POS_W = 8;
    localparam logic [SLOT_IDX_W-1:0] LAST_BIT_IDX = 3'h7;
    localparam logic [FRAME_POS_W-1:0] POS_FIRST = 8'h00;
    localparam logic [FRAME_POS_W-1:0] POS_AFTER_FIRST = 8'h01;
    localparam logic [FRAME_POS_W-1:0] POS_STEP = 8'h01;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic [DATA_W-1:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic clk;
        logic data;
        logic frame;
    } rx_line_t;
endpackage

//--- rx_timeslot_monitor_chk.sv
// Checker for the monitor's register ports.
// Assumes it is bound to the top module.
`timescale 1ns/1ps
module rx_timeslot_monitor_chk
    import rx_timeslot_monitor_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire host_req_t i_host,
    input wire rx_line_t i_rx_line,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic [SEL_W-1:0] o_chan_sel
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire logic wc = i_host.wr && i_host.addr == ADDR_COMMON_CONTROL_FIVE;
    chk_sel_load: assert property (wc |=> o_chan_sel == $past(i_host.wdata[SEL_MSB:SEL_LSB]))
        else $error("select not loaded");
    chk_sel_hold: assert property (!wc |=> $stable(o_chan_sel))
        else $error("select changed");
    chk_ctrl_read: assert property (
        i_host.rd && i_host.addr == 8'hAA |=> o_rdata == {3'h0, $past(o_chan_sel)})
        else $error("control read wrong");
    chk_rdata_hold: assert property (!i_host.rd |=> $stable(o_rdata))
        else $error("read data changed");
    chk_unmapped_zero: assert property (
        i_host.rd && i_host.addr[7:1] != 7'h55 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

//--- test_rx_timeslot_monitor.sv
// Random frames, channel selects and register reads.
// Assumes the checker is compiled first.
`timescale 1ns/1ps
module test_rx_timeslot_monitor;
    import rx_timeslot_monitor_pkg::*;
    logic i_core_clk = 0;
    logic i_rst = 1;
    host_req_t i_host = '0;
    rx_line_t i_rx_line = '0;
    logic [7:0] o_rdata;
    logic [4:0] o_chan_sel;
    logic [7:0] ts [32];
    logic [4:0] sel;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    rx_timeslot_monitor rx_timeslot_monitor_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_host(i_host), .i_rx_line(i_rx_line), .o_rdata(o_rdata), .o_chan_sel(o_chan_sel));
    initial forever #2 i_core_clk = ~i_core_clk;
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        i_host = '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge i_core_clk);
        i_host = '{addr: a, wr: 0, rd: 0, wdata: d};
        @(negedge i_core_clk);
    endtask
    function automatic logic [7:0] slot_of(input logic [4:0] ch);
        return ts[5'(ch - 5'h01)];
    endfunction
    // First bit of each slot sent first
    task automatic frame();
        for (int b = 0; b < 256; b++) begin
            @(negedge i_core_clk);
            i_rx_line = '{clk: 1'b0, data: ts[b / 8][7 - b % 8], frame: 1'(b == 0)};
            repeat (4) @(negedge i_core_clk);
            i_rx_line.clk = 1'b1;
            repeat (3) @(negedge i_core_clk);
        end
        i_rx_line.clk = 1'b0;
        repeat (8) @(negedge i_core_clk);
    endtask
    initial begin
        void'($urandom(8));
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst = 0;
        check({3'h0, o_chan_sel}, {3'h0, SEL_RESET});
        check(o_rdata, READ_ZERO);
        for (int f = 0; f < 4; f++) begin
            sel = f == 0 ? 5'h01 : f == 1 ? 5'h00 : 5'($urandom);
            foreach (ts[i]) ts[i] = 8'($urandom);
            access(1, 8'hAA, {3'h0, sel});
            check({3'h0, o_chan_sel}, {3'h0, sel});
            access(0, 8'hAA, 8'h00);
            check(o_rdata, {3'h0, sel});
            frame();
            access(1, 8'hAB, ~slot_of(sel));
            access(0, 8'hAB, 8'h00);
            check(o_rdata, slot_of(sel));
            access(0, 8'h10, 8'h00);
            check(o_rdata, 8'h00);
            $display("test %0d done", f);
        end
        // Reset in mid-run clears select and snapshot
        i_rst = 1;
        repeat (2) @(negedge i_core_clk);
        i_rst = 0;
        check({3'h0, o_chan_sel}, {3'h0, SEL_RESET});
        access(0, 8'hAB, 8'h00);
        check(o_rdata, SNAPSHOT_RESET);
        $display("test reset done");
        give_verdict();
    end
endmodule
bind rx_timeslot_monitor rx_timeslot_monitor_chk rx_timeslot_monitor_chk_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_host(i_host), .i_rx_line(i_rx_line),
    .o_rdata(o_rdata), .o_chan_sel(o_chan_sel));
